// ===== design/fpet_pkg.sv
// Package: constants and types for the flash program and erase timer
package fpet_pkg;
   localparam int DIV_W = 8;
   localparam int CMD_W = 3;
   localparam int ADDR_W = 16;

   localparam logic [CMD_W-1:0] CMD_PROGRAM = 3'h1;
   localparam logic [CMD_W-1:0] CMD_BURST   = 3'h2;
   localparam logic [CMD_W-1:0] CMD_SECTOR  = 3'h3;
   localparam logic [CMD_W-1:0] CMD_MASS    = 3'h4;
   localparam logic [CMD_W-1:0] CMD_BLANK   = 3'h5;

   localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;

   localparam logic [15:0] PGM_OP_CYCLES    = 16'h0009;
   localparam logic [15:0] PGM_BUS_CYCLES   = 16'h0019;
   localparam logic [15:0] BURST_OP_CYCLES  = 16'h0004;
   localparam logic [15:0] BURST_BUS_CYCLES = 16'h0009;
   localparam logic [6:0]  BURST_MAX_WORDS  = 7'h40;
   localparam logic [4:0]  ERASE_PULSES     = 5'h10;
   localparam logic [15:0] ERASE_OP_CYCLES  = 16'h0FA0;
   localparam logic [15:0] PULSE_OP_CYCLES  = 16'h00FA;
   localparam logic [15:0] MASS_OP_CYCLES   = 16'h4E20;
   localparam logic [15:0] BLANK_SETUP      = 16'h000A;
   localparam logic [ADDR_W:0] BLANK_WORDS  = 17'h10000;

   // Operating rate window of the operation clock, in kHz
   localparam int OPCLK_MIN_KHZ = 150;
   localparam int OPCLK_MAX_KHZ = 200;
   // Least bus rate for program or erase, in kHz (1.0 MHz)
   localparam int BUS_MIN_KHZ = 1000;

   typedef enum logic [2:0] {
      ST_IDLE, ST_PGM_OP, ST_PGM_BUS, ST_ERASE, ST_BLANK_SETUP, ST_BLANK_SCAN
   } fpet_state_t;
endpackage : fpet_pkg

// ===== design/fpet_op_divider.sv
// Operation clock divider producing a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
module fpet_op_divider (
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   input  wire logic [fpet_pkg::DIV_W-1:0] div_value,
   input  wire logic                     restart,
   output logic                          op_tick
);
   import fpet_pkg::*;
   logic [DIV_W-1:0] cnt_reg;

   // Tick every div_value+1 bus cycles
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
      end else if (restart || cnt_reg == div_value) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + DIV_W'(1);
      end
   end

   assign op_tick = !restart && (cnt_reg == div_value);
endmodule : fpet_op_divider
`default_nettype wire

// ===== design/fpet_cycle_counter.sv
// Loadable down counter for phase lengths
`timescale 1ns/1ps
`default_nettype none
module fpet_cycle_counter (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        load,
   input  wire logic [15:0] load_value,
   input  wire logic        step,
   output logic             zero
);
   logic [15:0] cnt_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
      end else if (load) begin
         cnt_reg <= load_value;
      end else if (step && cnt_reg != 16'h0000) begin
         cnt_reg <= cnt_reg - 16'h0001;
      end
   end

   assign zero = (cnt_reg == 16'h0000);
endmodule : fpet_cycle_counter
`default_nettype wire

// ===== design/fpet_flash_timer.sv
// Top: flash program, burst, erase and blank check sequencer
`timescale 1ns/1ps
`default_nettype none
module fpet_flash_timer (
   input  wire logic                        clk,
   input  wire logic                        arst_n,
   input  wire logic                        div_write,
   input  wire logic [fpet_pkg::DIV_W-1:0]  div_wdata,
   output logic      [fpet_pkg::DIV_W-1:0]  nvm_clock_divider_reg,
   input  wire logic                        cmd_valid,
   input  wire logic [fpet_pkg::CMD_W-1:0]  cmd_code,
   output logic                             cmd_ready,
   output logic                             busy,
   output logic                             done_flag,
   input  wire logic                        done_clear,
   output logic                             blank_fail,
   output logic                             program_pulse,
   output logic                             erase_pulse,
   output logic                             mass_erase,
   output logic      [fpet_pkg::ADDR_W-1:0] check_addr,
   input  wire logic                        check_word_blank
);
   import fpet_pkg::*;

   // ------------------------------------------------------------
   // State and wires
   // ------------------------------------------------------------
   fpet_state_t      state_reg;
   logic             burst_reg;
   logic [6:0]       words_reg;
   logic [4:0]       pulses_reg;
   logic             mass_reg;
   logic [ADDR_W:0]  scan_reg;
   logic             op_tick;
   logic             op_zero;
   logic             bus_zero;
   logic             op_load;
   logic [15:0]      op_load_value;
   logic             bus_load;
   logic [15:0]      bus_load_value;
   logic             start;
   logic             finish;
   logic             burst_next;
   logic             is_cmd;

   function automatic logic cmd_known(input logic [CMD_W-1:0] c);
      cmd_known = (c == CMD_PROGRAM) || (c == CMD_BURST) || (c == CMD_SECTOR) ||
                  (c == CMD_MASS) || (c == CMD_BLANK);
   endfunction : cmd_known

   // ------------------------------------------------------------
   // Divider register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nvm_clock_divider_reg <= DIV_RESET;
      end else if (div_write && state_reg == ST_IDLE) begin
         nvm_clock_divider_reg <= div_wdata;
      end
   end

   fpet_op_divider u_div (
      .clk       (clk),
      .arst_n    (arst_n),
      .div_value (nvm_clock_divider_reg),
      .restart   (start),
      .op_tick   (op_tick)
   );

   fpet_cycle_counter u_op_cnt (
      .clk        (clk),
      .arst_n     (arst_n),
      .load       (op_load),
      .load_value (op_load_value),
      .step       (op_tick),
      .zero       (op_zero)
   );

   fpet_cycle_counter u_bus_cnt (
      .clk        (clk),
      .arst_n     (arst_n),
      .load       (bus_load),
      .load_value (bus_load_value),
      .step       (1'b1),
      .zero       (bus_zero)
   );

   // ------------------------------------------------------------
   // Command handshake
   // ------------------------------------------------------------
   // No bus rate check: host keeps the bus at 1 MHz or more
   assign is_cmd     = cmd_valid && cmd_known(cmd_code);
   assign cmd_ready  = (state_reg == ST_IDLE) || burst_next;
   assign start      = (state_reg == ST_IDLE) && is_cmd;
   // Next burst word taken only if pending when the current word ends
   assign burst_next = (state_reg == ST_PGM_BUS) && bus_zero && burst_reg &&
                       (words_reg < BURST_MAX_WORDS) && cmd_valid &&
                       (cmd_code == CMD_BURST);

   always_comb begin
      op_load        = 1'b0;
      op_load_value  = 16'h0000;
      bus_load       = 1'b0;
      bus_load_value = 16'h0000;
      if (start) begin
         case (cmd_code)
            CMD_PROGRAM, CMD_BURST: begin
               op_load       = 1'b1;
               op_load_value = PGM_OP_CYCLES;
            end
            CMD_SECTOR: begin
               op_load       = 1'b1;
               op_load_value = PULSE_OP_CYCLES;
            end
            CMD_MASS: begin
               op_load       = 1'b1;
               op_load_value = MASS_OP_CYCLES;
            end
            CMD_BLANK: begin
               bus_load       = 1'b1;
               bus_load_value = BLANK_SETUP - 16'h0001;
            end
            default: begin
               op_load = 1'b0;
            end
         endcase
      end else if (burst_next) begin
         op_load       = 1'b1;
         op_load_value = BURST_OP_CYCLES;
      end else if (state_reg == ST_PGM_OP && op_zero) begin
         bus_load       = 1'b1;
         bus_load_value = burst_reg && words_reg != 7'h01 ?
                          BURST_BUS_CYCLES - 16'h0001 : PGM_BUS_CYCLES - 16'h0001;
      end else if (state_reg == ST_ERASE && op_zero && !mass_reg &&
                   pulses_reg != ERASE_PULSES) begin
         op_load       = 1'b1;
         op_load_value = PULSE_OP_CYCLES;
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  case (cmd_code)
                     CMD_PROGRAM, CMD_BURST: state_reg <= ST_PGM_OP;
                     CMD_SECTOR, CMD_MASS:   state_reg <= ST_ERASE;
                     CMD_BLANK:              state_reg <= ST_BLANK_SETUP;
                     default:                state_reg <= ST_IDLE;
                  endcase
               end
            end
            ST_PGM_OP: begin
               if (op_zero) begin
                  state_reg <= ST_PGM_BUS;
               end
            end
            ST_PGM_BUS: begin
               if (burst_next) begin
                  state_reg <= ST_PGM_OP;
               end else if (bus_zero) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_ERASE: begin
               if (op_zero && (mass_reg || pulses_reg == ERASE_PULSES)) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_BLANK_SETUP: begin
               if (bus_zero) begin
                  state_reg <= ST_BLANK_SCAN;
               end
            end
            ST_BLANK_SCAN: begin
               if (!check_word_blank || scan_reg == BLANK_WORDS - 17'h00001) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Burst bookkeeping
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         burst_reg <= 1'b0;
         words_reg <= 7'h00;
      end else if (start) begin
         burst_reg <= (cmd_code == CMD_BURST);
         words_reg <= 7'h01;
      end else if (burst_next) begin
         words_reg <= words_reg + 7'h01;
      end
   end

   // Erase pulse bookkeeping
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pulses_reg <= 5'h00;
         mass_reg   <= 1'b0;
      end else if (start) begin
         pulses_reg <= 5'h01;
         mass_reg   <= (cmd_code == CMD_MASS);
      end else if (op_load && state_reg == ST_ERASE) begin
         pulses_reg <= pulses_reg + 5'h01;
      end
   end

   // Blank scan address
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scan_reg <= '0;
      end else if (start) begin
         scan_reg <= '0;
      end else if (state_reg == ST_BLANK_SCAN && check_word_blank) begin
         scan_reg <= scan_reg + 17'h00001;
      end
   end

   assign finish = (state_reg != ST_IDLE) && (state_reg != ST_PGM_OP) &&
                   (state_reg != ST_BLANK_SETUP) &&
                   ((state_reg == ST_PGM_BUS && bus_zero && !burst_next) ||
                    (state_reg == ST_ERASE && op_zero &&
                     (mass_reg || pulses_reg == ERASE_PULSES)) ||
                    (state_reg == ST_BLANK_SCAN &&
                     (!check_word_blank || scan_reg == BLANK_WORDS - 17'h00001)));

   // Done flag: completion wins over a clear in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         done_flag <= 1'b0;
      end else if (finish) begin
         done_flag <= 1'b1;
      end else if (done_clear || start) begin
         done_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         blank_fail <= 1'b0;
      end else if (start) begin
         blank_fail <= 1'b0;
      end else if (state_reg == ST_BLANK_SCAN && !check_word_blank) begin
         blank_fail <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Array strobes
   // ------------------------------------------------------------
   assign busy          = (state_reg != ST_IDLE);
   assign program_pulse = (state_reg == ST_PGM_OP);
   assign erase_pulse   = (state_reg == ST_ERASE) && !op_zero;
   assign mass_erase    = (state_reg == ST_ERASE) && mass_reg;
   assign check_addr    = scan_reg[ADDR_W-1:0];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Operation ticks spent in an erase, for the duration checks
   logic [15:0]      era_ticks_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         era_ticks_reg <= 16'h0000;
      end else if (start) begin
         era_ticks_reg <= 16'h0000;
      end else if (state_reg == ST_ERASE && op_tick && !op_zero) begin
         era_ticks_reg <= era_ticks_reg + 16'h0001;
      end
   end

   sequence s_word_end;
      state_reg == ST_PGM_BUS && bus_zero;
   endsequence

   a_div_hold: assert property (@(posedge clk) disable iff (!arst_n)
      busy |=> $stable(nvm_clock_divider_reg))
      else $error("divider changed during operation");
   a_single_bus: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == ST_PGM_OP && op_zero && !burst_reg) |=> ##24 s_word_end)
      else $error("single word bus phase not 25 cycles");
   a_burst_bus: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == ST_PGM_OP && op_zero && burst_reg && words_reg != 7'h01)
      |=> ##8 s_word_end)
      else $error("burst word bus phase not 9 cycles");
   a_burst_limit: assert property (@(posedge clk) disable iff (!arst_n)
      words_reg <= BURST_MAX_WORDS)
      else $error("burst longer than one row");
   a_burst_chain: assert property (@(posedge clk) disable iff (!arst_n)
      burst_next |=> state_reg == ST_PGM_OP && words_reg > 7'h01)
      else $error("burst word not chained");
   a_pulse_count: assert property (@(posedge clk) disable iff (!arst_n)
      pulses_reg <= ERASE_PULSES)
      else $error("too many erase pulses");
   a_sector_end: assert property (@(posedge clk) disable iff (!arst_n)
      (finish && state_reg == ST_ERASE && !mass_reg)
      |-> era_ticks_reg == ERASE_OP_CYCLES)
      else $error("sector erase tick count wrong");
   a_mass_ticks: assert property (@(posedge clk) disable iff (!arst_n)
      (finish && state_reg == ST_ERASE && mass_reg)
      |-> era_ticks_reg == MASS_OP_CYCLES)
      else $error("mass erase tick count wrong");
   a_mass_once: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == ST_ERASE && mass_reg) |-> pulses_reg == 5'h01)
      else $error("mass erase split into pulses");
   a_blank_setup: assert property (@(posedge clk) disable iff (!arst_n)
      (start && cmd_code == CMD_BLANK) |=> ##9 (state_reg == ST_BLANK_SETUP && bus_zero)
      ##1 state_reg == ST_BLANK_SCAN)
      else $error("blank check setup not 10 cycles");
   a_done_set: assert property (@(posedge clk) disable iff (!arst_n)
      finish |=> done_flag && !busy)
      else $error("done flag missing after completion");
endmodule : fpet_flash_timer
`default_nettype wire

// ===== testbench/fpet_flash_array_model.sv
// Flash array model answering blank queries for the sequencer
`timescale 1ns/1ps
`default_nettype none
module fpet_flash_array_model (
   input  wire logic [fpet_pkg::ADDR_W-1:0] check_addr,
   input  wire logic [fpet_pkg::ADDR_W-1:0] dirty_addr,
   input  wire logic                        dirty_en,
   output logic                             check_word_blank
);
   import fpet_pkg::*;

   // -----------------------------------------------------------------
   // Array contents
   // -----------------------------------------------------------------
   // One programmed word; every other word reads as erased
   assign check_word_blank = !(dirty_en && (check_addr == dirty_addr));
endmodule : fpet_flash_array_model
`default_nettype wire

// ===== testbench/fpet_flash_timer_tb.sv
// Self-checking testbench for the flash program and erase timer
`timescale 1ns/1ps
`default_nettype none
module fpet_flash_timer_tb;
   import fpet_pkg::*;
   localparam int LIM = 30000;

   logic                clk;
   logic                arst_n;
   logic                div_write;
   logic [DIV_W-1:0]    div_wdata;
   logic [DIV_W-1:0]    nvm_clock_divider_reg;
   logic                cmd_valid;
   logic [CMD_W-1:0]    cmd_code;
   logic                cmd_ready;
   logic                busy;
   logic                done_flag;
   logic                done_clear;
   logic                blank_fail;
   logic                program_pulse;
   logic                erase_pulse;
   logic                mass_erase;
   logic [ADDR_W-1:0]   check_addr;
   logic                check_word_blank;
   logic [ADDR_W-1:0]   dirty_addr;
   int                  n_errors;
   int                  checks;
   bit                  saw_pgm;
   bit                  saw_mass;
   int                  eps;

   fpet_flash_timer i_dut (
      .clk(clk), .arst_n(arst_n), .div_write(div_write), .div_wdata(div_wdata),
      .nvm_clock_divider_reg(nvm_clock_divider_reg), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_ready(cmd_ready), .busy(busy), .done_flag(done_flag),
      .done_clear(done_clear), .blank_fail(blank_fail), .program_pulse(program_pulse),
      .erase_pulse(erase_pulse), .mass_erase(mass_erase), .check_addr(check_addr),
      .check_word_blank(check_word_blank)
   );

   fpet_flash_array_model i_array (
      .check_addr(check_addr), .dirty_addr(dirty_addr), .dirty_en(1'b1),
      .check_word_blank(check_word_blank)
   );

   // ------------------------------------------------------------------
   // Clock, reset and watchdog
   // ------------------------------------------------------------------
   always #12.5 clk = ~clk;

   initial begin
      #(60000 * 25);
      n_errors++;
      print_verdict();
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic set_div(input int d);
      div_write = 1'b1;
      div_wdata = d[DIV_W-1:0];
      @(posedge clk);
      #2;
      div_write = 1'b0;
      check(32'(nvm_clock_divider_reg), d);
   endtask : set_div

   // Checks duration band, completion flag, then clears the flag
   task automatic finish_op(input int n, input int lo, input int hi);
      check(32'(n >= lo && n <= hi), 32'h1);
      check(32'({done_flag, busy}), 32'h2);
      done_clear = 1'b1;
      @(posedge clk);
      #2;
      done_clear = 1'b0;
      check(32'(done_flag), 32'h0);
   endtask : finish_op

   // Starts one command and counts cycles to the done flag
   task automatic run_op(input logic [CMD_W-1:0] code, input int d, input bit poke,
                         output int n);
      bit prev_ep;
      set_div(d);
      cmd_code = code;
      cmd_valid = 1'b1;
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      n = 0;
      prev_ep = 1'b0;
      saw_pgm = 1'b0;
      saw_mass = 1'b0;
      eps = 0;
      while (done_flag !== 1'b1 && n < LIM) begin
         saw_pgm |= (program_pulse === 1'b1);
         saw_mass |= (mass_erase === 1'b1);
         if (erase_pulse === 1'b1 && !prev_ep) eps++;
         prev_ep = (erase_pulse === 1'b1);
         if (poke && n == 3) begin
            cmd_valid = 1'b1;
            cmd_code = CMD_MASS;
            div_write = 1'b1;
            div_wdata = 8'h55;
         end
         if (poke && n == 4) begin
            cmd_valid = 1'b0;
            cmd_code = code;
            div_write = 1'b0;
         end
         @(posedge clk);
         #2;
         n++;
      end
   endtask : run_op

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset();
      check(32'({busy, done_flag, blank_fail, cmd_ready}), 32'h1);
      check(32'(nvm_clock_divider_reg), 32'(DIV_RESET));
   endtask : t_reset

   // Reset in the middle of a mass erase returns the block to idle
   task automatic t_reset_mid();
      set_div(3);
      cmd_code = CMD_MASS;
      cmd_valid = 1'b1;
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      repeat (50) @(posedge clk);
      #2;
      check(32'({busy, mass_erase}), 32'h3);
      arst_n = 1'b0;
      #1;
      check(32'({busy, done_flag, cmd_ready}), 32'h1);
      repeat (2) @(posedge clk);
      #2;
      arst_n = 1'b1;
      t_reset();
      repeat (2) @(posedge clk);
      #2;
      check(32'({busy, done_flag}), 32'h0);
   endtask : t_reset_mid

   task automatic t_unknown(input logic [CMD_W-1:0] code);
      cmd_code = code;
      cmd_valid = 1'b1;
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      @(posedge clk);
      #2;
      check(32'(busy), 32'h0);
   endtask : t_unknown

   // Single word program; a command and divider write arrive mid-op
   task automatic t_program(input int d);
      int n;
      int nom;
      nom = 9 * (d + 1) + 25;
      run_op(CMD_PROGRAM, d, 1'b1, n);
      check(32'({saw_pgm, saw_mass}), 32'h2);
      check(32'(nvm_clock_divider_reg), d);
      finish_op(n, nom - (d + 1), nom + (d + 1) + 2);
   endtask : t_program

   // Burst: the pipeline stays filled until the last word is chained;
   // a full row keeps it filled to the end, so a further word must be refused
   task automatic t_burst(input int d, input int words);
      int n;
      int ch;
      int nom;
      nom = 9 * (d + 1) + 25 + (words - 1) * (4 * (d + 1) + 9);
      set_div(d);
      cmd_code = CMD_BURST;
      cmd_valid = 1'b1;
      @(posedge clk);
      #2;
      n = 0;
      ch = 0;
      while (done_flag !== 1'b1 && n < LIM) begin
         if (ch >= words - 1 && words < 32'(BURST_MAX_WORDS)) cmd_valid = 1'b0;
         if (busy === 1'b1 && cmd_ready === 1'b1 && cmd_valid) ch++;
         @(posedge clk);
         #2;
         n++;
      end
      cmd_valid = 1'b0;
      check(ch, words - 1);
      finish_op(n, nom - (d + 1) * words, nom + (d + 3) * words);
   endtask : t_burst

   task automatic t_erase(input logic [CMD_W-1:0] code, input int d, input int ticks);
      int n;
      int nom;
      int tol;
      nom = ticks * (d + 1);
      tol = nom / 100 + 16 * (d + 1) + 4;
      run_op(code, d, 1'b0, n);
      if (code == CMD_SECTOR) check(eps, 16);
      else check(32'(saw_mass), 32'h1);
      finish_op(n, nom - tol, nom + tol);
   endtask : t_erase

   task automatic t_blank(input int a);
      int n;
      dirty_addr = a[ADDR_W-1:0];
      run_op(CMD_BLANK, 0, 1'b0, n);
      check(32'(blank_fail), 32'h1);
      check(32'(check_addr), a);
      finish_op(n, 11 + a, 12 + a);
   endtask : t_blank

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      div_write = 1'b0;
      div_wdata = 8'h00;
      cmd_valid = 1'b0;
      cmd_code = 3'h0;
      done_clear = 1'b0;
      dirty_addr = 16'h0000;
      n_errors = 0;
      checks = 0;
      repeat (6) @(posedge clk);
      #2;
      arst_n = 1'b1;
      t_reset();
      t_unknown(3'h0);
      t_unknown(3'h7);
      t_reset_mid();
      t_program(3);
      t_program(199);
      t_burst(3, 3);
      t_burst(0, 64);
      t_erase(CMD_SECTOR, 1, 4000);
      t_erase(CMD_MASS, 0, 20000);
      t_blank(0);
      t_blank(5);
      t_blank(300);
      print_verdict();
   end
endmodule : fpet_flash_timer_tb
`default_nettype wire
